// *** hdl/uepf_epmem.sv ***
// endpoint configuration memory with registered read port
`timescale 1ns/10ps
`default_nettype none
module uepf_epmem #(
  parameter int DEPTH = `UEPF_NUM_EP,
  parameter int IDX_W = `UEPF_EP_W
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [IDX_W-1:0]         wr_idx,
  input  wire uepf_pkg::uepf_epcfg_type wr_data,
  // read side
  input  wire logic [IDX_W-1:0]         rd_idx,
  output uepf_pkg::uepf_epcfg_type      rd_data
);
  typedef struct packed {
    uepf_pkg::uepf_epcfg_type [DEPTH-1:0] mem;
    uepf_pkg::uepf_epcfg_type             rd;
  } uepf_mem_st_type;

  uepf_mem_st_type q;
  uepf_mem_st_type d;

  always_comb
  begin
    d = q;
    if (wr_en && wr_idx < IDX_W'(DEPTH))
    begin
      d.mem[wr_idx] = wr_data;
    end
    d.rd = (rd_idx < IDX_W'(DEPTH)) ? q.mem[rd_idx] : '0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
endmodule
`default_nettype wire

// *** hdl/uepf_top.sv ***
// usb endpoint packet flow: control-in, endpoint map, error recovery, host frame and data path
// How it works
// RQ1: write request identifier into channel one status
// RQ2: first control-in token: save identifier, NAK
// RQ3: retry with response loaded sends the data
// RQ4: while pending, NAK others, record nothing
// RQ5: after acknowledged data, next token becomes pending
// RQ6: eleven physical endpoints, five interfaces at most
// RQ7: each endpoint holds programmable logical identity
// RQ8: any endpoint may map to any interface
// RQ9: endpoint zero uses OUT and IN FIFOs
// RQ10: stuffing or CRC fault is transmission error
// RQ11: unacknowledged IN: pulse interrupt, reset endpoint FIFO
// RQ12: per-endpoint readable count of sent packets
// RQ13: refetch plus enable refetches descriptor on arbitration; a grant in the cycle of an OUT error is dropped and its refetch flag cleared
// RQ14: FIFO release lets refetch resend remaining data
// RQ15: OUT error closes buffer with error status
// RQ16: OUT error fetches the next descriptor
// RQ17: host: SOF every millisecond, then four lists
// RQ18: host data passes a four-word FIFO
// RQ19: bursts of two words, split per descriptor
// RQ20: host pulses interrupt per retired descriptor
// RQ21: configuration masters use single word accesses
// RQ22: decode five configuration windows
// RQ23: host and device blocks never both active
// RQ24: channels three to twelve serve endpoints one-ten
// RQ25: one pending flag, set on save, cleared on ack
`timescale 1ns/10ps
`default_nettype none
module uepf_top #(
  parameter int SOF_CYCLES = `UEPF_SOF_CYC,
  parameter int FIFO_DEPTH = `UEPF_HFIFO_DEPTH
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // mode
  input  wire logic                      dev_mode_sel,
  output logic                           host_blk_rst,
  output logic                           dev_blk_rst,
  // configuration address decode
  input  wire logic                      cfg_valid,
  input  wire logic [31:0]               cfg_addr,
  output uepf_pkg::uepf_region_type      cfg_region,
  output logic                           cfg_miss,
  // endpoint programming
  input  wire logic                      ep_wr_en,
  input  wire logic [`UEPF_EP_W-1:0]     ep_wr_idx,
  input  wire uepf_pkg::uepf_epcfg_type  ep_wr_data,
  output logic                           ep_wr_err,
  input  wire logic [`UEPF_EP_W-1:0]     ep_rd_idx,
  output uepf_pkg::uepf_epcfg_type       ep_rd_data,
  // control-in
  input  wire logic                      ctl_in_tok,
  input  wire logic                      ctl_resp_ready,
  input  wire logic                      ctl_in_acked,
  output logic                           ctl_nak,
  output logic                           ctl_send,
  output logic                           ctl_pending,
  output logic                           ch1_stat_we,
  output logic [`UEPF_ID_W-1:0]          ch1_stat_id,
  // packet results from the serial engine
  input  wire logic                      pkt_done,
  input  wire logic [`UEPF_EP_W-1:0]     pkt_ep,
  input  wire logic                      pkt_dir_in,
  input  wire logic                      pkt_stuff_err,
  input  wire logic                      pkt_crc_err,
  input  wire logic                      pkt_acked,
  output logic                           in_err_irq,
  output logic [`UEPF_EP_W-1:0]          in_err_ep,
  output logic [`UEPF_NUM_EP-1:0]        fifo_in_reset,
  output logic                           out_err_close,
  output logic [`UEPF_CH_W-1:0]          out_err_ch,
  input  wire logic [`UEPF_EP_W-1:0]     cnt_rd_idx,
  output logic [`UEPF_CNT_W-1:0]         cnt_rd_data,
  // dma control
  input  wire logic                      dma_ctl_we,
  input  wire logic [`UEPF_CH_W-1:0]     dma_ctl_ch,
  input  wire logic                      dma_ctl_refetch,
  input  wire logic                      dma_ctl_enable,
  input  wire logic                      fifo_release,
  input  wire logic [`UEPF_EP_W-1:0]     fifo_release_ep,
  input  wire logic                      dma_arb_win,
  input  wire logic [`UEPF_CH_W-1:0]     dma_arb_ch,
  output uepf_pkg::uepf_fetch_type       desc_fetch,
  // host frame and lists
  input  wire logic                      list_done,
  input  wire logic                      td_retire,
  output logic                           sof_send,
  output logic                           list_start,
  output logic [1:0]                     list_sel,
  output logic                           td_irq,
  // host data fifo
  input  wire logic                      hf_in_valid,
  output logic                           hf_in_ready,
  input  wire uepf_pkg::uepf_hword_type  hf_in_data,
  output logic                           bm_valid,
  input  wire logic                      bm_ready,
  output uepf_pkg::uepf_hword_type       bm_data,
  output logic                           bm_last
);
  localparam int NEP = `UEPF_NUM_EP;
  localparam int PW  = $clog2(FIFO_DEPTH);
  localparam int CW  = $clog2(SOF_CYCLES);
  localparam int BW  = `UEPF_BURST_BYTES / `UEPF_WORD_BYTES;
  localparam int BCW = $clog2(BW + 1);

  typedef struct packed {
    logic                                 pend;
    logic [`UEPF_ID_W-1:0]                id;
    logic [`UEPF_ID_W-1:0]                id_next;
    logic                                 nak;
    logic                                 send;
    logic                                 stat_we;
    logic [NEP-1:0]                       fifo_rst;
    logic [NEP-1:0][`UEPF_CNT_W-1:0]      cnt;
    logic [`UEPF_NUM_CH-1:0]              refetch;
    uepf_pkg::uepf_fetch_type             fetch;
    logic                                 in_err;
    logic [`UEPF_EP_W-1:0]                in_err_ep;
    logic                                 out_err;
    logic [`UEPF_CH_W-1:0]                out_err_ch;
    logic [`UEPF_CNT_W-1:0]               cnt_rd;
  } uepf_dev_type;

  typedef struct packed {
    uepf_pkg::uepf_hstate_type            st;
    logic [CW-1:0]                        tmr;
    logic [1:0]                           list;
    logic                                 sof;
    logic                                 lstart;
    logic                                 td_irq;
    uepf_pkg::uepf_hword_type [FIFO_DEPTH-1:0] mem;
    logic [PW-1:0]                        wp;
    logic [PW-1:0]                        rp;
    logic [PW:0]                          cnt;
    logic [BCW-1:0]                       bcnt;
  } uepf_host_type;

  typedef struct packed {
    logic                                 host_run;
    logic                                 dev_run;
    uepf_pkg::uepf_region_type            region;
    logic                                 miss;
    logic                                 wr_err;
    uepf_dev_type                         dev;
    uepf_host_type                        host;
  } uepf_st_type;

  function automatic uepf_st_type rst_val();
    uepf_st_type s;
    s = '0;
    s.host.st = uepf_pkg::UEPF_H_IDLE;
    return s;
  endfunction

  localparam uepf_st_type ST_RST = rst_val();

  // endpoint zero splits by direction over the two control channels
  function automatic logic [`UEPF_CH_W-1:0] ep_to_ch(input logic [`UEPF_EP_W-1:0] ep, input logic dir_in);
    if (ep == '0)
      return (dir_in == `UEPF_DIR_IN) ? `UEPF_CH_CTL_IN : `UEPF_CH_CTL_OUT; // [RQ9]
    return `UEPF_CH_W'({1'b0, ep}) + `UEPF_CH_EP_BASE; // [RQ24]
  endfunction

  // channels above twelve map to no endpoint
  function automatic logic [`UEPF_EP_W-1:0] ch_to_ep(input logic [`UEPF_CH_W-1:0] ch);
    if (ch == `UEPF_CH_CTL_OUT || ch == `UEPF_CH_CTL_IN)
      return '0;
    if (ch >= `UEPF_CH_FIRST_EP && ch <= `UEPF_CH_LAST_EP)
      return `UEPF_EP_W'(ch - `UEPF_CH_EP_BASE); // [RQ24]
    return `UEPF_EP_NONE;
  endfunction

  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base, input int sh);
    return (a >> sh) == (base >> sh);
  endfunction

  uepf_st_type q;
  uepf_st_type d;
  uepf_pkg::uepf_epcfg_type ep_wdata;
  logic                     ep_wr_ok;
  logic                     xmit_err;
  logic                     pend_now;
  logic                     ep_ok;
  logic [`UEPF_EP_W-1:0]    arb_ep;
  logic                     push;
  logic                     pop;
  logic [PW-1:0]            rp_nxt;

  always_comb
  begin
    ep_wdata = ep_wr_data;
    if (ep_wr_idx == '0)
      ep_wdata.xtype = `UEPF_TYPE_CTRL; // [RQ9]
    // interface field must name one of five; any endpoint may take any of them
    ep_wr_ok = ep_wr_en && ep_wr_idx < `UEPF_EP_W'(NEP) && ep_wr_data.intf < `UEPF_NUM_INTF; // [RQ6] [RQ8]
    xmit_err = pkt_stuff_err | pkt_crc_err; // [RQ10]
    pend_now = q.dev.pend & ~ctl_in_acked;
    ep_ok = pkt_done && pkt_ep < `UEPF_EP_W'(NEP);
    arb_ep = ch_to_ep(dma_arb_ch);
    push = hf_in_valid & hf_in_ready;
    pop = bm_valid & bm_ready;
    rp_nxt = q.host.rp + PW'(1);
  end

  always_comb
  begin
    d = q;
    d.host_run = ~dev_mode_sel & ~q.dev_run; // [RQ23]
    d.dev_run = dev_mode_sel & ~q.host_run; // [RQ23]
    d.region.glb = cfg_valid & win_hit(cfg_addr, `UEPF_GLB_BASE, `UEPF_WIN4K_SHIFT); // [RQ22]
    d.region.host = cfg_valid & win_hit(cfg_addr, `UEPF_HOST_BASE, `UEPF_WIN4K_SHIFT);
    d.region.dev = cfg_valid & win_hit(cfg_addr, `UEPF_DEV_BASE, `UEPF_WIN4K_SHIFT);
    d.region.fifo = cfg_valid & win_hit(cfg_addr, `UEPF_FIFO_BASE, `UEPF_WIN4K_SHIFT);
    d.region.dma = cfg_valid & win_hit(cfg_addr, `UEPF_DMA_BASE, `UEPF_WIN64K_SHIFT);
    d.miss = cfg_valid & ~(|d.region);
    d.wr_err = ep_wr_en & ~ep_wr_ok;
    d.dev.nak = 1'b0;
    d.dev.send = 1'b0;
    d.dev.stat_we = 1'b0;
    d.dev.in_err = 1'b0;
    d.dev.out_err = 1'b0;
    d.dev.fetch = '0;
    d.dev.cnt_rd = (cnt_rd_idx < `UEPF_EP_W'(NEP)) ? q.dev.cnt[cnt_rd_idx] : '0; // [RQ12]
    // ack clears first so a token in the same cycle starts a new request
    if (ctl_in_tok)
    begin
      if (!pend_now)
      begin
        d.dev.pend = 1'b1; // [RQ25] [RQ5]
        d.dev.id = q.dev.id_next; // [RQ2]
        d.dev.id_next = q.dev.id_next + `UEPF_ID_W'(1);
        d.dev.stat_we = 1'b1; // [RQ1]
        d.dev.nak = 1'b1; // [RQ2]
      end
      else if (ctl_resp_ready)
        d.dev.send = 1'b1; // [RQ3]
      else
        d.dev.nak = 1'b1; // [RQ4]
    end
    else if (ctl_in_acked)
      d.dev.pend = 1'b0; // [RQ25]
    if (dma_ctl_we && dma_ctl_refetch && dma_ctl_enable && dma_ctl_ch != '0)
      d.dev.refetch[4'(dma_ctl_ch - `UEPF_CH_CTL_OUT)] = 1'b1; // [RQ13]
    // a stalled channel's grant is dropped; it wins again once its fifo is back
    if (dma_arb_win && arb_ep != `UEPF_EP_NONE && !q.dev.fifo_rst[arb_ep] && dma_arb_ch != '0
        && q.dev.refetch[4'(dma_arb_ch - `UEPF_CH_CTL_OUT)])
    begin
      d.dev.refetch[4'(dma_arb_ch - `UEPF_CH_CTL_OUT)] = 1'b0;
      d.dev.fetch = '{valid: 1'b1, ch: dma_arb_ch, refetch: 1'b1}; // [RQ13] [RQ14]
      d.dev.cnt[arb_ep] = '0;
    end
    if (fifo_release && fifo_release_ep < `UEPF_EP_W'(NEP))
      d.dev.fifo_rst[fifo_release_ep] = 1'b0; // [RQ14]
    if (ep_ok && pkt_dir_in)
    begin
      if (pkt_acked)
        d.dev.cnt[pkt_ep] = q.dev.cnt[pkt_ep] + `UEPF_CNT_W'(1); // [RQ12]
      else
      begin
        d.dev.in_err = 1'b1; // [RQ11]
        d.dev.in_err_ep = pkt_ep;
        d.dev.fifo_rst[pkt_ep] = 1'b1; // [RQ11]
      end
    end
    // out error owns the fetch port this cycle; a colliding refetch grant is lost, its refetch flag already cleared
    if (ep_ok && !pkt_dir_in && xmit_err)
    begin
      d.dev.out_err = 1'b1; // [RQ15]
      d.dev.out_err_ch = ep_to_ch(pkt_ep, `UEPF_DIR_OUT);
      d.dev.fetch = '{valid: 1'b1, ch: ep_to_ch(pkt_ep, `UEPF_DIR_OUT), refetch: 1'b0}; // [RQ16]
    end
    if (!q.dev_run)
      d.dev = ST_RST.dev; // [RQ23]

    d.host.sof = 1'b0;
    d.host.lstart = 1'b0;
    d.host.td_irq = td_retire; // [RQ20]
    if (pop)
    begin
      d.host.rp = rp_nxt;
      d.host.bcnt = bm_last ? '0 : q.host.bcnt + BCW'(1);
    end
    if (push)
    begin
      d.host.mem[q.host.wp] = hf_in_data; // [RQ18]
      d.host.wp = q.host.wp + PW'(1);
    end
    d.host.cnt = q.host.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (q.host.tmr == '0)
    begin
      // a late walk is cut short: the new frame restarts at the first list
      d.host.tmr = CW'(SOF_CYCLES - 1);
      d.host.sof = 1'b1; // [RQ17]
      d.host.list = '0;
      d.host.st = uepf_pkg::UEPF_H_LIST;
    end
    else
    begin
      d.host.tmr = q.host.tmr - CW'(1);
      unique case (q.host.st)
        uepf_pkg::UEPF_H_IDLE: ;
        uepf_pkg::UEPF_H_LIST:
        begin
          d.host.lstart = 1'b1; // [RQ17]
          d.host.st = uepf_pkg::UEPF_H_WAIT;
        end
        uepf_pkg::UEPF_H_WAIT:
        begin
          if (list_done)
          begin
            d.host.st = (q.host.list == `UEPF_LAST_LIST) ? uepf_pkg::UEPF_H_IDLE : uepf_pkg::UEPF_H_LIST;
            d.host.list = q.host.list + 2'h1;
          end
        end
        default: d.host.st = uepf_pkg::UEPF_H_IDLE;
      endcase
    end
    if (!q.host_run)
      d.host = ST_RST.host; // [RQ23]
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      q <= ST_RST;
    end
    else
    begin
      q <= d;
    end
  end

  uepf_epmem #(
    .DEPTH (NEP),
    .IDX_W (`UEPF_EP_W)
  ) u_epmem (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (ep_wr_ok),
    .wr_idx  (ep_wr_idx),
    .wr_data (ep_wdata),
    .rd_idx  (ep_rd_idx),
    .rd_data (ep_rd_data)
  ); // [RQ7]

  assign host_blk_rst  = ~q.host_run;
  assign dev_blk_rst   = ~q.dev_run;
  assign cfg_region    = q.region;
  assign cfg_miss      = q.miss;
  assign ep_wr_err     = q.wr_err;
  assign ctl_nak       = q.dev.nak;
  assign ctl_send      = q.dev.send;
  assign ctl_pending   = q.dev.pend;
  assign ch1_stat_we   = q.dev.stat_we;
  assign ch1_stat_id   = q.dev.id;
  assign in_err_irq    = q.dev.in_err;
  assign in_err_ep     = q.dev.in_err_ep;
  assign fifo_in_reset = q.dev.fifo_rst;
  assign out_err_close = q.dev.out_err;
  assign out_err_ch    = q.dev.out_err_ch;
  assign cnt_rd_data   = q.dev.cnt_rd;
  assign desc_fetch    = q.dev.fetch;
  assign sof_send      = q.host.sof;
  assign list_start    = q.host.lstart;
  assign list_sel      = q.host.list;
  assign td_irq        = q.host.td_irq;
  assign hf_in_ready   = q.host_run && q.host.cnt != (PW+1)'(FIFO_DEPTH); // [RQ18]
  assign bm_valid      = q.host_run && q.host.cnt != '0;
  assign bm_data       = q.host.mem[q.host.rp];
  // burst ends at two words, at the last word held, or where the descriptor changes
  assign bm_last       = q.host.bcnt == BCW'(BW - 1) || q.host.cnt == (PW+1)'(1)
                         || q.host.mem[rp_nxt].td != q.host.mem[q.host.rp].td; // [RQ19]

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_first_nak;
    ctl_in_tok && !ctl_pending && !ctl_in_acked |=> ctl_nak && ctl_pending && ch1_stat_we && !ctl_send;
  endproperty
  a_first_nak: assert property (p_first_nak) else $error("first control-in token not saved and NAKed"); // [RQ2]

  property p_id_step;
    ch1_stat_we ##1 (!ch1_stat_we [*1]) ##1 ch1_stat_we |-> ch1_stat_id == $past(ch1_stat_id, 2) + 8'h01;
  endproperty
  a_id_step: assert property (p_id_step) else $error("request identifier did not advance"); // [RQ1]

  property p_retry_send;
    ctl_in_tok && ctl_pending && !ctl_in_acked && ctl_resp_ready |=> ctl_send && !ctl_nak;
  endproperty
  a_retry_send: assert property (p_retry_send) else $error("retry with response loaded not sent"); // [RQ3]

  property p_pend_nak;
    ctl_in_tok && ctl_pending && !ctl_in_acked && !ctl_resp_ready |=> ctl_nak && !ch1_stat_we && $stable(ch1_stat_id);
  endproperty
  a_pend_nak: assert property (p_pend_nak) else $error("pending token not NAKed or identifier recorded"); // [RQ4]

  property p_ack_clear;
    ctl_in_acked && !ctl_in_tok && !dev_blk_rst |=> !ctl_pending;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("pending flag kept after acknowledged data"); // [RQ5]

  property p_in_err;
    pkt_done && pkt_dir_in && !pkt_acked && pkt_ep == 4'h3 && !dev_blk_rst && !dev_mode_sel == 1'b0
      |=> in_err_irq && in_err_ep == 4'h3 && fifo_in_reset[3];
  endproperty
  a_in_err: assert property (p_in_err) else $error("unacknowledged IN did not reset its fifo"); // [RQ11]

  property p_out_err;
    pkt_done && !pkt_dir_in && (pkt_stuff_err || pkt_crc_err) && pkt_ep == 4'h2 && !dev_blk_rst && dev_mode_sel
      |=> out_err_close && desc_fetch.valid && !desc_fetch.refetch && desc_fetch.ch == 5'h04;
  endproperty
  a_out_err: assert property (p_out_err) else $error("OUT error did not close buffer and fetch next"); // [RQ15] [RQ16]

  property p_exclusive;
    !(!host_blk_rst && !dev_blk_rst);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("host and device blocks both active"); // [RQ23]

  property p_sof_walk;
    sof_send && !host_blk_rst && !dev_mode_sel |=> list_start && list_sel == 2'h0;
  endproperty
  a_sof_walk: assert property (p_sof_walk) else $error("list walk did not follow start of frame"); // [RQ17]

  property p_burst;
    bm_valid && bm_ready && !bm_last |=> bm_valid && bm_last;
  endproperty
  a_burst: assert property (p_burst) else $error("burst longer than two words"); // [RQ19]
endmodule
`default_nettype wire

// *** inc/uepf_defines.svh ***
// constants of the usb endpoint packet-flow block
`ifndef UEPF_DEFINES_SVH
`define UEPF_DEFINES_SVH
`define UEPF_NUM_EP        11
`define UEPF_NUM_INTF      4'h5
`define UEPF_EP_W          4
`define UEPF_CH_W          5
`define UEPF_NUM_CH        16
`define UEPF_CH_CTL_OUT    5'h01
`define UEPF_CH_CTL_IN     5'h02
`define UEPF_CH_EP_BASE    5'h02
`define UEPF_CH_FIRST_EP   5'h03
`define UEPF_CH_LAST_EP    5'h0C
`define UEPF_EP_NONE       4'hF
`define UEPF_TYPE_CTRL     2'h0
`define UEPF_DIR_OUT       1'h0
`define UEPF_DIR_IN        1'h1
`define UEPF_ID_W          8
`define UEPF_CNT_W         16
`define UEPF_WORD_W        32
`define UEPF_TD_W          4
`define UEPF_SOF_PERIOD_US 1000
`define UEPF_CLK_MHZ       100
`define UEPF_SOF_CYC       (`UEPF_SOF_PERIOD_US * `UEPF_CLK_MHZ)
`define UEPF_LAST_LIST     2'h3
`define UEPF_HFIFO_DEPTH   4
`define UEPF_BURST_BYTES   8
`define UEPF_WORD_BYTES    4
`define UEPF_WIN4K_SHIFT   12
`define UEPF_WIN64K_SHIFT  16
`define UEPF_GLB_BASE      32'h90100000
`define UEPF_HOST_BASE     32'h90101000
`define UEPF_DEV_BASE      32'h90102000
`define UEPF_FIFO_BASE     32'h90103000
`define UEPF_DMA_BASE      32'h90110000
`endif

// *** inc/uepf_pkg.sv ***
// types shared by the usb endpoint packet-flow block
`include "uepf_defines.svh"
package uepf_pkg;
  typedef struct packed {
    logic [3:0]  cfg;
    logic [3:0]  intf;
    logic [3:0]  alt;
    logic [1:0]  xtype;
    logic        dir;
    logic [10:0] maxpkt;
  } uepf_epcfg_type;

  typedef struct packed {
    logic glb;
    logic host;
    logic dev;
    logic fifo;
    logic dma;
  } uepf_region_type;

  typedef struct packed {
    logic                  valid;
    logic [`UEPF_CH_W-1:0] ch;
    logic                  refetch;
  } uepf_fetch_type;

  typedef struct packed {
    logic [`UEPF_WORD_W-1:0] data;
    logic [`UEPF_TD_W-1:0]   td;
  } uepf_hword_type;

  typedef enum logic [2:0] {
    UEPF_H_IDLE = 3'h1,
    UEPF_H_LIST = 3'h2,
    UEPF_H_WAIT = 3'h4
  } uepf_hstate_type;
endpackage

// *** verif/uepf_bm_model.sv ***
// bus-master sink model that drains the host fifo
`timescale 1ns/10ps
`default_nettype none
module uepf_bm_model (
  // clock and stall control
  input  wire logic                     mclk,
  input  wire logic                     hold,
  // drain side of the host fifo
  input  wire logic                     bm_valid,
  output logic                          bm_ready,
  input  wire uepf_pkg::uepf_hword_type bm_data,
  // what was taken
  output logic [31:0]                   sum,
  output logic [7:0]                    n_got
);
  initial
  begin
    bm_ready = 1'b0;
    sum = 32'h0;
    n_got = 8'h0;
  end
  // random stalls so the fifo sees back-pressure mid-drain
  always @(posedge mclk)
  begin
    if (bm_valid && bm_ready)
    begin
      sum <= sum + bm_data.data;
      n_got <= n_got + 8'h1;
    end
    bm_ready <= !hold && ($urandom & 1);
  end
endmodule
`default_nettype wire

// *** verif/uepf_top_tb.sv ***
// self-checking bench for the endpoint packet-flow block
`timescale 1ns/10ps
`default_nettype none
module uepf_top_tb;
  logic mclk, reset, mode, cv, tok, rdy, ack, pd, pin, pse, pce, pak, hv, hold, dwe, arb, frl, bmr;
  logic miss, hrst, drst, nak, snd, pend, swe, ierr, oerr, hrdy, bmv, sof, lst;
  logic [31:0] ca, sum, sum_e;
  logic        ld;
  logic [3:0]  cri;
  logic [15:0] cnt;
  logic [7:0]  sid, got;
  logic [3:0]  pep, iep, e, fep;
  logic [4:0]  och, dch, ach;
  logic [10:0] frst;
  logic [1:0]  lsel;
  uepf_pkg::uepf_region_type rg;
  uepf_pkg::uepf_fetch_type  df;
  uepf_pkg::uepf_hword_type  hd, bmd;
  int err_count, n_tests, cyc, i, n;
  logic [31:0] base [6] = '{32'h90100000, 32'h90101000, 32'h90102000, 32'h90103000, 32'h90110000, 32'h90104000};
  uepf_top #(.SOF_CYCLES(50), .FIFO_DEPTH(4)) dut (.mclk(mclk), .reset(reset), .dev_mode_sel(mode),
    .host_blk_rst(hrst), .dev_blk_rst(drst), .cfg_valid(cv), .cfg_addr(ca), .cfg_region(rg), .cfg_miss(miss),
    .ep_wr_en(1'b0), .ep_wr_idx(4'h0), .ep_wr_data('0), .ep_wr_err(), .ep_rd_idx(4'h0), .ep_rd_data(),
    .ctl_in_tok(tok), .ctl_resp_ready(rdy), .ctl_in_acked(ack), .ctl_nak(nak), .ctl_send(snd),
    .ctl_pending(pend), .ch1_stat_we(swe), .ch1_stat_id(sid), .pkt_done(pd), .pkt_ep(pep), .pkt_dir_in(pin),
    .pkt_stuff_err(pse), .pkt_crc_err(pce), .pkt_acked(pak), .in_err_irq(ierr), .in_err_ep(iep),
    .fifo_in_reset(frst), .out_err_close(oerr), .out_err_ch(och), .cnt_rd_idx(cri), .cnt_rd_data(cnt),
    .dma_ctl_we(dwe), .dma_ctl_ch(dch), .dma_ctl_refetch(dwe), .dma_ctl_enable(dwe), .fifo_release(frl),
    .fifo_release_ep(fep), .dma_arb_win(arb), .dma_arb_ch(ach), .desc_fetch(df), .list_done(ld),
    .td_retire(pd), .sof_send(sof), .list_start(lst), .list_sel(lsel), .td_irq(), .hf_in_valid(hv),
    .hf_in_ready(hrdy), .hf_in_data(hd), .bm_valid(bmv), .bm_ready(bmr), .bm_data(bmd), .bm_last());
  uepf_bm_model bm (.mclk(mclk), .hold(hold), .bm_valid(bmv), .bm_ready(bmr), .bm_data(bmd), .sum(sum),
    .n_got(got));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [4:0] ch_of(input logic [3:0] ep, input logic din);
    return (ep == 4'h0) ? (din ? 5'h02 : 5'h01) : 5'(ep) + 5'h02;
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] x);
    n_tests++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tk(input logic r, input logic a, input logic [2:0] x);
    rdy = r;
    ack = a;
    tok = 1'b1;
    @(negedge mclk);
    tok = 1'b0;
    ack = 1'b0;
    chk({nak, snd, swe}, x);
    @(negedge mclk);
  endtask
  task automatic pk(input logic din, input logic se, input logic ce, input logic ak);
    {pin, pse, pce, pak, pd} = {din, se, ce, ak, 1'b1};
    @(negedge mclk);
    pd = 1'b0;
  endtask
  task automatic conclude();
    $display("counts: tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    {reset, mode, hold} = 3'h7;
    {cv, tok, rdy, ack, pd, pin, pse, pce, pak, hv, dwe, arb, frl, ld} = '0;
    {ca, pep, dch, ach, fep, hd, sum_e, cri} = '0;
    void'($urandom(32'h3243));
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    chk({hrst, drst}, 2'h2);
    for (i = 0; i < 6; i++)
    begin
      ca = base[i] + ($urandom & 32'hFFF);
      cv = 1'b1; // one single-word access at a time
      @(negedge mclk);
      cv = 1'b0;
      chk({rg, miss}, 6'h20 >> i);
      @(negedge mclk);
    end
    $display("test decode done");
    tk(1'b0, 1'b0, 3'h5);
    chk({pend, sid}, 9'h100);
    tk(1'b0, 1'b0, 3'h4);
    tk(1'b1, 1'b0, 3'h2);
    tk(1'b0, 1'b1, 3'h5);
    chk(sid, 8'h01);
    ack = 1'b1;
    @(negedge mclk);
    ack = 1'b0;
    chk(pend, 1'b0);
    tk(1'b0, 1'b0, 3'h5);
    chk(sid, 8'h02);
    $display("test control-in done");
    for (i = 0; i < 4; i++)
    begin
      pep = 4'($urandom_range(0, 10));
      pk(1'b0, i[1], i[0], 1'b1);
      chk({oerr, df.valid, df.refetch}, {{2{i != 0}}, 1'b0});
      if (i != 0)
        chk(och, ch_of(pep, 1'b0));
    end
    e = 4'($urandom_range(1, 10));
    pep = e;
    pk(1'b1, 1'b0, 1'b0, 1'b0);
    chk({ierr, iep, frst[e]}, {1'b1, e, 1'b1});
    dch = ch_of(e, 1'b1);
    ach = dch;
    dwe = 1'b1;
    @(negedge mclk);
    {dwe, arb} = 2'h1;
    @(negedge mclk);
    arb = 1'b0;
    chk(df.valid, 1'b0);
    {frl, fep} = {1'b1, e};
    @(negedge mclk);
    {frl, arb} = 2'h1;
    @(negedge mclk);
    arb = 1'b0;
    chk({df, frst[e]}, {1'b1, dch, 1'b1, 1'b0});
    cri = e;
    pk(1'b1, 1'b0, 1'b0, 1'b1);
    @(negedge mclk);
    chk(cnt, 16'h0001);
    $display("test error recovery done");
    mode = 1'b0;
    for (i = 0; i < 10 && hrst; i++)
      @(negedge mclk);
    chk({hrst, drst}, 2'h1);
    for (i = 0; i < 60 && !sof; i++)
      @(negedge mclk);
    chk(sof, 1'b1);
    @(negedge mclk);
    chk({lst, lsel}, 3'h4);
    ld = 1'b1;
    @(negedge mclk);
    ld = 1'b0;
    @(negedge mclk);
    chk({lst, lsel}, 3'h5);
    for (n = 0; n < 8 && hrdy; n++)
    begin
      hd.data = $urandom;
      sum_e += hd.data;
      hv = 1'b1;
      @(negedge mclk);
    end
    hv = 1'b0;
    chk(36'(n), 36'h4);
    hold = 1'b0;
    for (i = 0; i < 60 && got < 8'h4; i++)
      @(negedge mclk);
    chk({sum, got}, {sum_e, 8'h04});
    $display("test host path done");
    conclude();
  end
endmodule
`default_nettype wire
